// file: design/rac_defines.svh
// Contract
// - Read/write bits read back the last value software stored.
// - Read-only bits ignore software writes and still read their value.
// - Write-only bits take writes; their read value is undefined.
// - Reserved bits always read as zero, whatever was written.
// - Power-on reset loads all reset values; peripheral software reset does too, except debug control and status.
// - Base register and its companions all read the base contents.
// - Writing the set companion forces the written one bits of the base high.
// - Writing one into the clear companion clears that base bit.
// - Writing one into the toggle companion inverts that base bit.
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

// Register indices on the local access port
`define RAC_ADDR_CTRL      4'h0
`define RAC_ADDR_STATUS    4'h1
`define RAC_ADDR_COMMAND   4'h2
`define RAC_ADDR_DBGCTRL   4'h3
`define RAC_ADDR_OUT       4'h4
`define RAC_ADDR_OUT_SET    4'h5
`define RAC_ADDR_OUT_CLEAR  4'h6
`define RAC_ADDR_OUT_TOGGLE 4'h7
`define RAC_ADDR_EN         4'h8
`define RAC_ADDR_EN_SET     4'h9
`define RAC_ADDR_EN_CLEAR   4'ha
`define RAC_ADDR_EN_TOGGLE  4'hb

// Implemented bits; everything else is reserved
`define RAC_MASK_CTRL      8'h7f
`define RAC_MASK_STATUS    8'h0f
`define RAC_MASK_COMMAND   8'h03
`define RAC_MASK_DBGCTRL   8'h03
`define RAC_MASK_OUT       8'hff
`define RAC_MASK_EN        8'h3f

// Command register fields
`define RAC_CMD_SWRST_BIT  0
`define RAC_CMD_PULSE_BIT  1

// Reset values
`define RAC_RST_CTRL       8'h00
`define RAC_RST_DBGCTRL    8'h00
`define RAC_RST_OUT        8'h00
`define RAC_RST_EN         8'h00
`define RAC_RST_STATUS     8'h00

`endif

// file: design/rac_pkg.sv
package rac_pkg;

  // Register data word
  typedef logic [7:0] rac_byte_t;

  // Register address index
  typedef logic [3:0] rac_addr_t;

  // Action a write applies to a paired base register
  typedef enum logic [2:0] {
    RAC_OP_NONE,
    RAC_OP_WRITE,
    RAC_OP_SET,
    RAC_OP_CLEAR,
    RAC_OP_TOGGLE
  } rac_op_t;

endpackage : rac_pkg

// file: design/rac_companion.sv
`timescale 1ns/1ps
// Next value of a base register under a plain, set, clear or toggle write
module rac_companion
  import rac_pkg::*;
(
  input  rac_op_t   op,
  input  rac_byte_t base,
  input  rac_byte_t data,
  input  rac_byte_t mask,
  output rac_byte_t next_value
);

  // Only written one bits move under a companion write; reserved bits stay zero
  always_comb begin
    case (op)
      RAC_OP_WRITE:  next_value = data & mask;
      RAC_OP_SET:    next_value = (base | data) & mask;
      RAC_OP_CLEAR:  next_value = base & ~data & mask;
      RAC_OP_TOGGLE: next_value = (base ^ data) & mask;
      RAC_OP_NONE:   next_value = base;
      default:       next_value = base;
    endcase
  end

endmodule : rac_companion

// file: design/rac_bank.sv
`timescale 1ns/1ps
`include "rac_defines.svh"
// Peripheral register bank on a local synchronous access port.
// Holds one control register, a status register, a command register,
// a debug control register and two base registers with set, clear and
// toggle companions.
module rac_bank
  import rac_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      resetn,
  input  wire logic      soft_reset,
  input  wire logic      acc_write,
  input  wire logic      acc_read,
  input  wire rac_addr_t acc_addr,
  input  wire rac_byte_t acc_wdata,
  input  wire rac_byte_t status_in,
  output rac_byte_t      rd_data,
  output logic           rd_valid,
  output rac_byte_t      ctrl_value,
  output rac_byte_t      dbg_value,
  output rac_byte_t      out_value,
  output rac_byte_t      en_value,
  output logic           cmd_pulse
);

  // Stored register contents
  rac_byte_t ctrl;
  rac_byte_t dbgctrl;
  rac_byte_t out_base;
  rac_byte_t en_base;
  rac_byte_t status;
  rac_byte_t next_out;
  rac_byte_t next_en;
  rac_op_t   out_op;
  rac_op_t   en_op;
  logic      cmd_write;
  logic      periph_reset;

  // Implemented-bit mask of each index; unmapped indices have none
  function automatic rac_byte_t reg_mask(input rac_addr_t addr);
    case (addr)
      `RAC_ADDR_CTRL:    reg_mask = `RAC_MASK_CTRL;
      `RAC_ADDR_STATUS:  reg_mask = `RAC_MASK_STATUS;
      `RAC_ADDR_COMMAND: reg_mask = `RAC_MASK_COMMAND;
      `RAC_ADDR_DBGCTRL: reg_mask = `RAC_MASK_DBGCTRL;
      `RAC_ADDR_OUT,
      `RAC_ADDR_OUT_SET,
      `RAC_ADDR_OUT_CLEAR,
      `RAC_ADDR_OUT_TOGGLE: reg_mask = `RAC_MASK_OUT;
      `RAC_ADDR_EN,
      `RAC_ADDR_EN_SET,
      `RAC_ADDR_EN_CLEAR,
      `RAC_ADDR_EN_TOGGLE:  reg_mask = `RAC_MASK_EN;
      default:           reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  // Which action a write at addr applies to the pair whose base sits at base_addr
  // Companions sit at base plus one, two and three, so pairs use aligned groups of four
  function automatic rac_op_t pair_op(input logic      wr,
                                      input rac_addr_t addr,
                                      input rac_addr_t base_addr);
    rac_op_t op;
    op = RAC_OP_NONE;
    if (wr) begin
      if (addr == base_addr) begin
        op = RAC_OP_WRITE;
      end else if (addr == base_addr + 4'h1) begin
        op = RAC_OP_SET;
      end else if (addr == base_addr + 4'h2) begin
        op = RAC_OP_CLEAR;
      end else if (addr == base_addr + 4'h3) begin
        op = RAC_OP_TOGGLE;
      end
    end
    pair_op = op;
  endfunction : pair_op

  // Decode the pair action separately for each base register, both through the one pair_op function
  assign out_op = pair_op(acc_write, acc_addr, `RAC_ADDR_OUT);
  assign en_op  = pair_op(acc_write, acc_addr, `RAC_ADDR_EN);

  // Command register write and the resulting peripheral reset
  // Reset wins over a same-edge write to control or either base; that write is lost, not queued
  assign cmd_write    = acc_write && (acc_addr == `RAC_ADDR_COMMAND);
  assign periph_reset = soft_reset ||
                        (cmd_write && acc_wdata[`RAC_CMD_SWRST_BIT]);

  // Output pair next value
  // Masking inside the pair keeps reserved bits zero whatever software writes
  rac_companion u_out_pair (
    .op         (out_op),
    .base       (out_base),
    .data       (acc_wdata),
    .mask       (`RAC_MASK_OUT),
    .next_value (next_out)
  );

  // Enable pair next value
  rac_companion u_en_pair (
    .op         (en_op),
    .base       (en_base),
    .data       (acc_wdata),
    .mask       (`RAC_MASK_EN),
    .next_value (next_en)
  );

  // Control register; reserved bit dropped at write time
  // Top bit is reserved and never stored, so it cannot leak into a read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `RAC_RST_CTRL;
    end else if (periph_reset) begin
      ctrl <= `RAC_RST_CTRL;
    end else if (acc_write && acc_addr == `RAC_ADDR_CTRL) begin
      ctrl <= acc_wdata & `RAC_MASK_CTRL;
    end
  end

  // Debug control survives the peripheral reset so a debugger keeps its setup
  // Only resetn clears it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dbgctrl <= `RAC_RST_DBGCTRL;
    end else if (acc_write && acc_addr == `RAC_ADDR_DBGCTRL) begin
      dbgctrl <= acc_wdata & `RAC_MASK_DBGCTRL;
    end
  end

  // Output base register, changed by itself or any companion
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_base <= `RAC_RST_OUT;
    end else if (periph_reset) begin
      out_base <= `RAC_RST_OUT;
    end else begin
      out_base <= next_out;
    end
  end

  // Enable base register, same companion scheme
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_base <= `RAC_RST_EN;
    end else if (periph_reset) begin
      en_base <= `RAC_RST_EN;
    end else begin
      en_base <= next_en;
    end
  end

  // Status follows its source only; writes to its index have no path here
  // No synchroniser: the status source runs on this clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status <= `RAC_RST_STATUS;
    end else begin
      status <= status_in & `RAC_MASK_STATUS;
    end
  end

  // Command strobe: write-only, acts once and keeps nothing readable
  // Nothing is stored, so a read of this index has no value to show
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_pulse <= 1'b0;
    end else begin
      cmd_pulse <= cmd_write && acc_wdata[`RAC_CMD_PULSE_BIT];
    end
  end

  // Read data, one cycle after the request; old contents if written alongside
  // Command reads give zero, but software must not rely on that value
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (acc_read) begin
      case (acc_addr)
        `RAC_ADDR_CTRL:    rd_data <= ctrl & reg_mask(acc_addr);
        `RAC_ADDR_STATUS:  rd_data <= status & reg_mask(acc_addr);
        `RAC_ADDR_COMMAND: rd_data <= 8'h00;
        `RAC_ADDR_DBGCTRL: rd_data <= dbgctrl & reg_mask(acc_addr);
        `RAC_ADDR_OUT,
        `RAC_ADDR_OUT_SET,
        `RAC_ADDR_OUT_CLEAR,
        `RAC_ADDR_OUT_TOGGLE: rd_data <= out_base & reg_mask(acc_addr);
        `RAC_ADDR_EN,
        `RAC_ADDR_EN_SET,
        `RAC_ADDR_EN_CLEAR,
        `RAC_ADDR_EN_TOGGLE:  rd_data <= en_base & reg_mask(acc_addr);
        default:           rd_data <= 8'h00;
      endcase
    end
  end

  // Read strobe marks the cycle rd_data is fresh
  // Holds one cycle; rd_data itself stays until the next read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= acc_read;
    end
  end

  // Register copies drive the block outputs straight from flops
  // Copies lag the registers by one cycle, traded for flop-driven outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_value <= `RAC_RST_CTRL;
      dbg_value  <= `RAC_RST_DBGCTRL;
      out_value  <= `RAC_RST_OUT;
      en_value   <= `RAC_RST_EN;
    end else begin
      ctrl_value <= ctrl;
      dbg_value  <= dbgctrl;
      out_value  <= out_base;
      en_value   <= en_base;
    end
  end

endmodule : rac_bank

// file: tb/rac_bank_sva.sv
`timescale 1ns/1ps
// Port watch on the bank; each *_value copy lags its register by one cycle
module rac_bank_sva
  import rac_pkg::*;
(
  input wire logic      clock,
  input wire logic      resetn,
  input wire logic      soft_reset,
  input wire logic      acc_write,
  input wire logic      acc_read,
  input wire rac_addr_t acc_addr,
  input wire rac_byte_t acc_wdata,
  input wire rac_byte_t status_in,
  input wire rac_byte_t rd_data,
  input wire logic      rd_valid,
  input wire rac_byte_t ctrl_value,
  input wire rac_byte_t dbg_value,
  input wire rac_byte_t out_value,
  input wire rac_byte_t en_value,
  input wire logic      cmd_pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Old base shows on the copy one edge after a write, new base two edges after
  read_pulse_a: assert property (rd_valid == $past(acc_read)) else $error("read pulse");
  set_apply_a: assert property (acc_write && acc_addr == 4'h5 && !soft_reset |=> ##1
    out_value == ($past(out_value) | $past(acc_wdata, 2))) else $error("set result");
  clear_apply_a: assert property (acc_write && acc_addr == 4'ha && !soft_reset |=> ##1
    en_value == ($past(en_value) & ~$past(acc_wdata, 2))) else $error("clear result");
  toggle_apply_a: assert property (acc_write && acc_addr == 4'h7 && !soft_reset |=> ##1
    out_value == ($past(out_value) ^ $past(acc_wdata, 2))) else $error("toggle result");
  periph_reset_a: assert property (soft_reset || acc_write && acc_addr == 4'h2 && acc_wdata[0]
    |=> ##1 {ctrl_value, out_value, en_value} == 24'h0) else $error("reset values");
  debug_keep_a: assert property (soft_reset && !(acc_write && acc_addr == 4'h3) |=> ##1
    dbg_value == $past(dbg_value)) else $error("debug lost");
  alias_read_a: assert property (acc_read && acc_addr[3:2] == 2'b01
    |=> rd_data == out_value) else $error("alias read");
  unmapped_zero_a: assert property (acc_read && acc_addr[3:2] == 2'b11
    |=> rd_data == 8'h00) else $error("unmapped read");
  cmd_strobe_a: assert property (cmd_pulse == $past(acc_write && acc_addr == 4'h2
    && acc_wdata[1])) else $error("command pulse");
  // Main traffic kinds seen at least once
  cover property (soft_reset);
  cover property (acc_write && acc_addr == 4'hb);
  cover property (acc_read && acc_addr == 4'hf);
  cover property (cmd_pulse);
endmodule : rac_bank_sva

// file: tb/tb_register_access_conventions.sv
`timescale 1ns/1ps
module tb_register_access_conventions;
  import rac_pkg::*;
  logic        clock, resetn, soft_reset, acc_write, acc_read, rd_valid, cmd_pulse;
  rac_addr_t   acc_addr;
  rac_byte_t   acc_wdata, status_in, rd_data, ctrl_value, dbg_value, out_value, en_value;
  rac_byte_t   m_ctrl, m_dbg, m_out, m_en, m_stat;
  logic [31:0] seed;
  int          fail_count = 0;
  int          samples_checked = 0;
  // Implemented bits per index; zero marks reserved or unmapped
  rac_byte_t   imp [16] = '{8'h7f, 8'h0f, 8'h03, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff,
                            8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
  rac_bank u_dut (.clock, .resetn, .soft_reset, .acc_write, .acc_read, .acc_addr, .acc_wdata,
    .status_in, .rd_data, .rd_valid, .ctrl_value, .dbg_value, .out_value, .en_value, .cmd_pulse);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Shift register; one new bit per call, so callers step it several times
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input rac_byte_t seen, input rac_byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  // One write cycle; the model follows at the same edge
  task automatic wr(input rac_addr_t a, input rac_byte_t d);
    rac_byte_t dm;
    dm = d & imp[a];
    @(negedge clock);
    acc_write = 1'b1;
    acc_addr = a;
    acc_wdata = d;
    case (a)
      4'h0: m_ctrl = dm;
      4'h2: if (d[0]) {m_ctrl, m_out, m_en} = 24'h0;
      4'h3: m_dbg = dm;
      4'h4: m_out = dm;
      4'h5: m_out |= dm;
      4'h6: m_out &= ~dm;
      4'h7: m_out ^= dm;
      4'h8: m_en = dm;
      4'h9: m_en |= dm;
      4'ha: m_en &= ~dm;
      4'hb: m_en ^= dm;
      default: ;
    endcase
    @(negedge clock);
    acc_write = 1'b0;
    check({7'h0, cmd_pulse}, {7'h0, (a == 4'h2) && d[1]});
  endtask : wr
  // Write-only command read data is left unchecked; rd_valid is still checked
  task automatic rd(input rac_addr_t a);
    rac_byte_t e;
    case (a)
      4'h0: e = m_ctrl;
      4'h1: e = m_stat;
      4'h3: e = m_dbg;
      default: e = (a[3:2] == 2'b01) ? m_out : (a[3:2] == 2'b10) ? m_en : 8'h00;
    endcase
    @(negedge clock);
    acc_read = 1'b1;
    acc_addr = a;
    @(negedge clock);
    acc_read = 1'b0;
    check({7'h0, rd_valid}, 8'h01);
    if (a != 4'h2) check(rd_data, e);
  endtask : rd
  task automatic outs;
    check(ctrl_value, m_ctrl);
    check(dbg_value, m_dbg);
    check(out_value, m_out);
    check(en_value, m_en);
  endtask : outs
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    {soft_reset, acc_write, acc_read, acc_addr, acc_wdata, status_in} = '0;
    {m_ctrl, m_dbg, m_out, m_en, m_stat} = '0;
    seed = 32'd94028;
    resetn = 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    outs;
    // Every alias of the output base after each companion write
    wr(4'h4, 8'h3c);
    for (int a = 5; a < 8; a++) begin
      wr(rac_addr_t'(a), 8'h0f);
      for (int b = 4; b < 8; b++) rd(rac_addr_t'(b));
    end
    $display("test companions done");
    // Ones into reserved positions must still read back as zero
    for (int a = 0; a < 16; a++) begin
      if (a != 2) begin
        wr(rac_addr_t'(a), 8'hff);
        rd(rac_addr_t'(a));
      end
    end
    $display("test reserved done");
    // Random traffic with occasional peripheral resets between accesses
    for (int i = 0; i < 500; i++) begin
      repeat (8) seed = lfsr(seed);
      if (seed[2:0] == 3'h0) begin
        @(negedge clock);
        soft_reset = 1'b1;
        {m_ctrl, m_out, m_en} = 24'h0;
        @(negedge clock);
        soft_reset = 1'b0;
      end
      status_in = seed[15:8];
      m_stat = seed[15:8] & 8'h0f;
      wr(seed[19:16], seed[27:20] & imp[seed[19:16]]);
      rd(seed[31:28]);
      outs;
    end
    $display("test random done");
    // Mid-run power-on style reset clears debug control as well
    @(negedge clock);
    resetn = 1'b0;
    {m_ctrl, m_dbg, m_out, m_en} = '0;
    @(negedge clock);
    resetn = 1'b1;
    outs;
    $display("test reset done");
    close_out;
  end
endmodule : tb_register_access_conventions
bind rac_bank rac_bank_sva u_sva (.clock, .resetn, .soft_reset, .acc_write, .acc_read,
  .acc_addr, .acc_wdata, .status_in, .rd_data, .rd_valid, .ctrl_value, .dbg_value,
  .out_value, .en_value, .cmd_pulse);
